// ---- include/wdt_defs.svh ----
/*
  constants for the watchdog timer: prescaler ratios, counter width, reset values.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_CNT_W        16
`define WDT_PRE_W        14
`define WDT_DIV_LONG     14'h3fff
`define WDT_DIV_SHORT    14'h00ff
`define WDT_RELOAD_RST   16'h0000
`define WDT_CNT_RST      16'h0000
`define WDT_CNT_ALL_ONES 16'hffff
`define WDT_PRE_RST      14'h0000
`endif

// ---- include/wdt_pkg.sv ----
/*
  types shared by the watchdog design files.
  assumes wdt_defs.svh is on the include path.
*/
`include "wdt_defs.svh"
package wdt_pkg;
  typedef struct packed {
    logic srv;
    logic dis;
    logic ena;
  } wdt_cmd_type;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_WARN,
    ST_RESET
  } wdt_state_type;
endpackage

// ---- logic/wdt_prescaler.sv ----
/*
  prescaler producing a one-cycle tick every 256 or 16,384 clocks.
  assumes clear and enable come from logic on the same clock.
*/
`timescale 1ns/1ns
`include "wdt_defs.svh"
module wdt_prescaler #(
  parameter int PRE_W = `WDT_PRE_W
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic clr_i,
  input  wire logic long_i,
  output logic      tick_o
);
  logic [PRE_W-1:0] cnt_r;
  logic [PRE_W-1:0] cnt_nxt;
  logic [PRE_W-1:0] limit;
  logic             tick_nxt;
  logic             tick_r;
  always_comb begin
    limit    = long_i ? `WDT_DIV_LONG : `WDT_DIV_SHORT;
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (clr_i) begin
      cnt_nxt = `WDT_PRE_RST;
    end else if (run_i) begin
      if (cnt_r >= limit) begin
        cnt_nxt  = `WDT_PRE_RST;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r  <= `WDT_PRE_RST;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick_o = tick_r;
endmodule // wdt_prescaler

// ---- logic/watchdog_timer.sv ----
/*
  watchdog timer: 16-bit up counter behind a selectable prescaler, with
  disable, enable and service commands, prewarning then reset request.
  assumes commands are one-cycle pulses from logic on mclk_i.
*/
//
// Summary of operation
// - comes up enabled after every reset
// - disable stops, enable resumes, any time
// - overflow: prewarning first, then reset request
// - 16-bit counter, prescaler 16,384 or 256
// - reload value comes from software register
// - service before overflow reloads counter, clears prescaler
//
`timescale 1ns/1ns
`include "wdt_defs.svh"
module watchdog_timer
  import wdt_pkg::*;
#(
  parameter int CNT_W     = `WDT_CNT_W,
  parameter int WARN_TICKS = 1
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire wdt_pkg::wdt_cmd_type cmd_i,
  input  wire logic                 long_div_i,
  input  wire logic                 reload_wr_i,
  input  wire logic [CNT_W-1:0]     watchdog_reload_value_i,
  output logic                      prewarn_irq_o,
  output logic                      reset_req_o,
  output logic                      enabled_o,
  output logic [CNT_W-1:0]          count_o
);
  import wdt_pkg::*;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  // warn counter runs 0 .. WARN_TICKS-1, one step per tick
  localparam int WARN_W = $clog2(WARN_TICKS + 1);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wdt_state_type     st_r;
  wdt_state_type     st_nxt;
  logic              en_r;
  logic              en_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [CNT_W-1:0]  rel_r;
  logic [CNT_W-1:0]  rel_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic              rst_r;
  logic              rst_nxt;
  logic [WARN_W-1:0] warn_cnt_r;
  logic [WARN_W-1:0] warn_cnt_nxt;
  logic              tick;
  logic              run;
  logic              step;
  logic              at_top;
  logic              srv_ok;
  logic              warn_done;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // counting halts once the reset request stands
  assign run       = en_r && (st_r != ST_RESET);
  // a tick that meets a disabled watchdog is dropped
  assign step      = tick && en_r;
  assign at_top    = (cnt_r == `WDT_CNT_ALL_ONES);
  // service only before overflow
  // a late service must not hold off the reset request
  assign srv_ok    = cmd_i.srv && (st_r == ST_RUN);
  // last tick of the warning gap
  assign warn_done = (warn_cnt_r == WARN_W'(WARN_TICKS - 1));
  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // one tick per 16,384 or 256 clocks
  wdt_prescaler #(
    .PRE_W  (`WDT_PRE_W)
  ) u_pre (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .run_i  (run),
    .clr_i  (srv_ok),
    .long_i (long_div_i),
    .tick_o (tick)
  );
  // ----------------------------------------------------------------
  // reload register
  // ----------------------------------------------------------------
  always_comb begin
    rel_nxt = rel_r;
    if (reload_wr_i) begin
      rel_nxt = watchdog_reload_value_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rel_r <= `WDT_RELOAD_RST;
    end else begin
      rel_r <= rel_nxt;
    end
  end
  // ----------------------------------------------------------------
  // enable
  // ----------------------------------------------------------------
  always_comb begin
    en_nxt = en_r;
    if (cmd_i.dis) begin
      en_nxt = 1'b0;
    end else if (cmd_i.ena) begin
      en_nxt = 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      en_r <= 1'b1;
    end else begin
      en_r <= en_nxt;
    end
  end
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (srv_ok) begin
      cnt_nxt = rel_r;
    end else if (step && (st_r == ST_RUN)) begin
      if (at_top) begin
        cnt_nxt = rel_r;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= `WDT_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt  = st_r;
    irq_nxt = 1'b0;
    rst_nxt = rst_r;
    case (st_r)
      ST_RUN: begin
        if (!srv_ok && step && at_top) begin
          st_nxt  = ST_WARN;
          irq_nxt = 1'b1;
        end
      end
      ST_WARN: begin
        if (step && warn_done) begin
          st_nxt  = ST_RESET;
          rst_nxt = 1'b1;
        end
      end
      ST_RESET: begin
        // held until system reset clears it
        rst_nxt = 1'b1;
      end
      default: begin
        st_nxt = ST_RUN;
      end
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r  <= ST_RUN;
      irq_r <= 1'b0;
      rst_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      irq_r <= irq_nxt;
      rst_r <= rst_nxt;
    end
  end
  // ----------------------------------------------------------------
  // warning gap
  // ----------------------------------------------------------------
  always_comb begin
    warn_cnt_nxt = warn_cnt_r;
    // only counts inside the warning state
    if (st_r != ST_WARN) begin
      warn_cnt_nxt = '0;
    end else if (step && !warn_done) begin
      warn_cnt_nxt = warn_cnt_r + 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      warn_cnt_r <= '0;
    end else begin
      warn_cnt_r <= warn_cnt_nxt;
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a plain register
  assign prewarn_irq_o = irq_r;
  assign reset_req_o   = rst_r;
  assign enabled_o     = en_r;
  assign count_o       = cnt_r;
endmodule // watchdog_timer

// ---- testbench/wdt_assertions.sv ----
/* port checker for the watchdog timer.
   assumes a bind onto watchdog_timer, one clock. */
`timescale 1ns/1ns
module wdt_assertions
  import wdt_pkg::*;
#(parameter int CNT_W = 16) (
  input wire logic                 mclk_i,
  input wire logic                 rst_i,
  input wire wdt_pkg::wdt_cmd_type cmd_i,
  input wire logic                 long_div_i,
  input wire logic                 reload_wr_i,
  input wire logic [CNT_W-1:0]     watchdog_reload_value_i,
  input wire logic                 prewarn_irq_o,
  input wire logic                 reset_req_o,
  input wire logic                 enabled_o,
  input wire logic [CNT_W-1:0]     count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // shadow of reload, and overflow seen; service is refused once set
  logic             seen_r, seen_nxt;
  logic [CNT_W-1:0] rl_r, rl_nxt;
  always_comb begin
    seen_nxt = !rst_i && (seen_r || prewarn_irq_o);
    rl_nxt   = rst_i ? '0 : reload_wr_i ? watchdog_reload_value_i : rl_r;
  end
  always_ff @(posedge mclk_i) begin
    seen_r <= seen_nxt;
    rl_r   <= rl_nxt;
  end
  boot_on_a: assert property ($fell(rst_i) |-> enabled_o && count_o == '0)
    else $error("not enabled after reset");
  dis_stop_a: assert property (cmd_i.dis |=> !enabled_o)
    else $error("disable ignored");
  ena_go_a: assert property (cmd_i.ena && !cmd_i.dis |=> enabled_o)
    else $error("enable ignored");
  count_frozen_a: assert property (!enabled_o && !cmd_i.ena && !cmd_i.srv |=> $stable(count_o))
    else $error("counting while disabled");
  srv_load_a: assert property (cmd_i.srv && !cmd_i.dis && enabled_o && !reload_wr_i && !seen_r
    && !prewarn_irq_o |=> count_o == rl_r)
    else $error("service did not reload");
  warn_first_a: assert property ($rose(reset_req_o) |-> seen_r)
    else $error("reset request before prewarning");
  wrap_load_a: assert property (prewarn_irq_o |-> $past(count_o) == 16'hffff && count_o == rl_r)
    else $error("overflow not at all ones");
  step_up_a: assert property ($changed(count_o) && !$past(rst_i) && !$past(cmd_i.srv) && !prewarn_irq_o
    |-> count_o == $past(count_o) + 1'b1)
    else $error("count step not plus one");
  irq_pulse_a: assert property (prewarn_irq_o |=> !prewarn_irq_o)
    else $error("prewarning longer than one cycle");
  req_sticky_a: assert property (reset_req_o |=> reset_req_o)
    else $error("reset request dropped");
endmodule // wdt_assertions

bind watchdog_timer wdt_assertions #(.CNT_W(CNT_W)) u_wdt_assertions (
  .mclk_i                  (mclk_i),
  .rst_i                   (rst_i),
  .cmd_i                   (cmd_i),
  .long_div_i              (long_div_i),
  .reload_wr_i             (reload_wr_i),
  .watchdog_reload_value_i (watchdog_reload_value_i),
  .prewarn_irq_o           (prewarn_irq_o),
  .reset_req_o             (reset_req_o),
  .enabled_o               (enabled_o),
  .count_o                 (count_o)
);

// ---- testbench/testbench.sv ----
/* self-checking bench for the watchdog timer.
   assumes the checker is bound in by its own file. */
`timescale 1ns/1ns
module testbench;
  import wdt_pkg::*;
  logic        mclk_i = 1'h0, rst_i = 1'h1, long_div_i = 1'h0, reload_wr_i = 1'h0;
  wdt_cmd_type cmd_i = '0;
  logic [15:0] watchdog_reload_value_i = 16'h0000, count_o;
  logic        prewarn_irq_o, reset_req_o, enabled_o;
  int          n_errors = 0, checks_done = 0;
  always #4 mclk_i = ~mclk_i;
  watchdog_timer u_watchdog_timer (
    .mclk_i                  (mclk_i),
    .rst_i                   (rst_i),
    .cmd_i                   (cmd_i),
    .long_div_i              (long_div_i),
    .reload_wr_i             (reload_wr_i),
    .watchdog_reload_value_i (watchdog_reload_value_i),
    .prewarn_irq_o           (prewarn_irq_o),
    .reset_req_o             (reset_req_o),
    .enabled_o               (enabled_o),
    .count_o                 (count_o)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge mclk_i) rst_i <= 1'h1;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'h0;
    cyc(1);
  endtask
  task automatic cmd(input wdt_cmd_type c, input logic w, input logic [15:0] v);
    @(posedge mclk_i) cmd_i <= c;
    reload_wr_i <= w;
    watchdog_reload_value_i <= v;
    @(posedge mclk_i) cmd_i <= '0;
    reload_wr_i <= 1'h0;
    #1;
  endtask
  // bounded wait: sel 0 prewarning, 1 reset request
  task automatic await(input int sel);
    int k;
    for (k = 0; k < 1000 && !(sel ? reset_req_o : prewarn_irq_o); k++) cyc(1);
    if (k == 1000) begin
      n_errors++;
      $display("Error await %0d expected 1 seen 0", sel);
      give_verdict();
    end
  endtask
  task automatic t_boot;
    do_reset();
    chk("enabled", 16'h0001, enabled_o);
    chk("count", 16'h0000, count_o);
  endtask
  task automatic t_wrap;
    cmd(3'h0, 1'h1, 16'hfffd);
    cmd(3'h4, 1'h0, 16'hfffd);
    chk("count", 16'hfffd, count_o);
    cyc(300);
    chk("count", 16'hfffe, count_o);
    await(0);
    chk("reset_req", 16'h0000, reset_req_o);
    chk("count", 16'hfffd, count_o);
    // late service is refused and must not restart the prescaler
    cmd(3'h0, 1'h1, 16'h1234);
    cmd(3'h4, 1'h0, 16'h1234);
    chk("count", 16'hfffd, count_o);
    cyc(251);
    chk("reset_req", 16'h0000, reset_req_o);
    cyc(1);
    chk("reset_req", 16'h0001, reset_req_o);
    await(1);
    chk("reset_req", 16'h0001, reset_req_o);
  endtask
  task automatic t_gate;
    cmd(3'h2, 1'h0, 16'h0000);
    chk("enabled", 16'h0000, enabled_o);
    cmd(3'h3, 1'h0, 16'h0000);
    chk("enabled", 16'h0000, enabled_o);
    cyc(600);
    chk("count", 16'h0000, count_o);
    cmd(3'h1, 1'h0, 16'h0000);
    chk("enabled", 16'h0001, enabled_o);
    @(posedge mclk_i) long_div_i <= 1'h1;
    cmd(3'h4, 1'h0, 16'h0000);
    cyc(600);
    chk("count", 16'h0000, count_o);
    cyc(15784);
    chk("count", 16'h0000, count_o);
    cyc(1);
    chk("count", 16'h0001, count_o);
  endtask
  initial begin
    t_boot();
    t_wrap();
    do_reset();
    t_gate();
    give_verdict();
  end
endmodule // testbench
